// file: inc/bcc_pkg.sv
// Purpose: Shared constants and types of the bridge calibration control
// Assumes: 50 MHz clock
// Notes:   Gains are signed Q16.16; channel values saturate at 32 bits
`default_nettype none

package bcc_pkg;

	// ----------------
	// Timing
	// ----------------
	localparam int unsigned CLK_HZ      = 50_000_000;
	localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
	localparam int unsigned TICK_MS     = 100;
	localparam int unsigned CAL_MS      = 150;
	localparam int unsigned TEST_MS     = 70;
	localparam int unsigned TICK_CYC    = TICK_MS * CYC_PER_MS;
	localparam int unsigned CAL_CYC     = CAL_MS * CYC_PER_MS;
	localparam int unsigned TEST_CYC    = TEST_MS * CYC_PER_MS;
	localparam int          CNT_W       = 24;
	localparam int unsigned DFLT_INTV_MIN = 3;
	localparam logic [15:0] DFLT_INTV   = 16'(DFLT_INTV_MIN * 60 * 1000 / TICK_MS);
	localparam logic [15:0] DFLT_TEST_N = 16'h000A;

	// ----------------
	// Mailbox codes
	// ----------------
	localparam logic [15:0] CMD_NONE     = 16'h0000;
	localparam logic [15:0] CMD_TARE_TMP = 16'h0001;
	localparam logic [15:0] CMD_TARE_NV  = 16'h0002;
	localparam logic [15:0] CMD_ZERO     = 16'h0101;
	localparam logic [15:0] CMD_CAL      = 16'h0102;
	localparam logic [7:0]  STAT_OK      = 8'h00;
	localparam logic [7:0]  STAT_BAD     = 8'h01;
	localparam logic [7:0]  STAT_BUSY    = 8'hFF;
	localparam logic [1:0]  NV_TARE      = 2'h0;
	localparam logic [1:0]  NV_ZERO      = 2'h1;
	localparam logic [1:0]  NV_RATED     = 2'h2;

	// ----------------
	// Settings entries
	// ----------------
	localparam logic [1:0] CFG_LOAD      = 2'h0;
	localparam logic [1:0] CFG_CH1       = 2'h1;
	localparam logic [1:0] CFG_CH2       = 2'h2;
	localparam logic [7:0] SUB_AVG       = 8'h03;
	localparam logic [7:0] SUB_TARE      = 8'h22;
	localparam logic [7:0] SUB_INTV      = 8'h31;
	localparam logic [7:0] SUB_TEST_N    = 8'h32;
	localparam logic [7:0] SUB_USCL_OFS  = 8'h11;
	localparam logic [7:0] SUB_USCL_GAIN = 8'h12;
	localparam logic [7:0] SUB_UCAL_OFS  = 8'h17;
	localparam logic [7:0] SUB_UCAL_GAIN = 8'h18;
	localparam int unsigned GAIN_FRAC    = 16;
	localparam logic signed [31:0] GAIN_ONE = 32'sh0001_0000;
	localparam logic signed [31:0] V_MAX    = 32'sh7FFF_FFFF;
	localparam logic signed [31:0] V_MIN    = 32'sh8000_0000;

	// ----------------
	// Types
	// ----------------
	typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_CAL = 2'b01, PH_TEST = 2'b10} bcc_phase_type;
	typedef enum logic [1:0] {MB_IDLE = 2'b00, MB_EXEC = 2'b01, MB_NV = 2'b10} bcc_mb_type;

	typedef struct packed {
		logic start_cal;
		logic auto_cal_off_flag;
		logic tare;
	} bcc_ctl_type;

	typedef struct packed {
		logic        wr;
		logic [1:0]  obj;
		logic [7:0]  sub;
		logic [31:0] data;
	} bcc_cfg_type;

	typedef struct packed {
		logic [1:0]  addr;
		logic [31:0] data;
	} bcc_nv_type;

	typedef struct packed {
		logic [CNT_W-1:0] cyc;
		logic [15:0]      ticks;
		logic             due;
	} bcc_sched_st_type;

	typedef struct packed {
		logic signed [31:0] ucal_ofs;
		logic signed [31:0] ucal_gain;
		logic signed [31:0] uscl_ofs;
		logic signed [31:0] uscl_gain;
		logic signed [31:0] value;
	} bcc_vch_st_type;

	typedef struct packed {
		bcc_phase_type      phase;
		logic [CNT_W-1:0]   cnt;
		logic [15:0]        runs;
		logic               boot_pend;
		logic               trig_pend;
		logic               start_d;
		logic               tare_d;
		logic [15:0]        intv;
		logic [15:0]        test_n;
		logic               avg_on;
		logic signed [31:0] tare;
		logic signed [31:0] zero_bal;
		logic signed [31:0] rated;
		logic signed [31:0] load_val;
		bcc_mb_type         mb;
		logic [15:0]        req;
		logic [7:0]         status;
		logic [31:0]        resp;
		logic               nv_req;
		bcc_nv_type         nv;
		logic               cal_busy;
		logic               amp_cal;
		logic               amp_test;
	} bcc_top_st_type;

	// Offset then Q16.16 gain, saturated to the signed 32-bit code range
	function automatic logic signed [31:0] bcc_ofs_gain(
		input logic signed [31:0] x,
		input logic signed [31:0] ofs,
		input logic signed [31:0] gain
	);
		logic signed [65:0] p;
		p = (66'(x) + 66'(ofs)) * 66'(gain);
		p = p >>> GAIN_FRAC;
		if (p > 66'(V_MAX))
			return V_MAX;
		else if (p < 66'(V_MIN))
			return V_MIN;
		return p[31:0];
	endfunction : bcc_ofs_gain

endpackage : bcc_pkg

`default_nettype wire

// file: hdl/bcc_sched.sv
// Purpose: Interval timer for periodic self-calibration
// Assumes: interval counted in 100 ms ticks
// Notes:   restart reloads the timer; due is a one-cycle pulse
`default_nettype none

module bcc_sched
	import bcc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC
)(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        ce,
	input  wire logic        restart,
	input  wire logic [15:0] interval,
	output logic             due
);

	bcc_sched_st_type st_ff;
	bcc_sched_st_type nxt;

	// ----------------
	// Tick and interval count
	// ----------------
	always_comb
	begin
		nxt     = st_ff;
		nxt.due = 1'b0;
		if (restart)
		begin
			nxt.cyc   = '0;
			nxt.ticks = '0;
		end
		else if (st_ff.cyc == CNT_W'(TICK_CYCLES - 1))
		begin
			nxt.cyc = '0;
			if (st_ff.ticks + 16'h0001 >= interval)
			begin
				nxt.ticks = '0;
				nxt.due   = 1'b1;
			end
			else
				nxt.ticks = st_ff.ticks + 16'h0001;
		end
		else
			nxt.cyc = st_ff.cyc + 1'b1;
	end

	// Register the state
	always_ff @(posedge clk)
	begin
		if (reset)
			st_ff <= '0;
		else if (ce)
			st_ff <= nxt;
	end

	assign due = st_ff.due;

endmodule : bcc_sched

`default_nettype wire

// file: hdl/bcc_vchan.sv
// Purpose: One voltage channel with user calibration and user scaling
// Assumes: settings writes arrive on the shared settings strobe
// Notes:   Two offset/gain stages in series, each saturating
`default_nettype none

module bcc_vchan
	import bcc_pkg::*;
#(
	parameter logic [1:0] OBJ = CFG_CH1
)(
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               ce,
	input  wire bcc_cfg_type        cfg,
	input  wire logic signed [31:0] raw,
	output logic signed [31:0]      value
);

	localparam bcc_vch_st_type ST_RST = '{
		ucal_gain: GAIN_ONE,
		uscl_gain: GAIN_ONE,
		default:   '0
	};

	bcc_vch_st_type st_ff;
	bcc_vch_st_type nxt;

	// ----------------
	// Settings and value path
	// ----------------
	always_comb
	begin
		nxt = st_ff;
		if (cfg.wr && cfg.obj == OBJ)
		begin
			unique case (cfg.sub)
				SUB_UCAL_OFS:  nxt.ucal_ofs  = cfg.data;
				SUB_UCAL_GAIN: nxt.ucal_gain = cfg.data;
				SUB_USCL_OFS:  nxt.uscl_ofs  = cfg.data;
				SUB_USCL_GAIN: nxt.uscl_gain = cfg.data;
				default:       ;
			endcase
		end
		// Saturating code range of the channel
		nxt.value = bcc_ofs_gain(bcc_ofs_gain(raw, st_ff.ucal_ofs, st_ff.ucal_gain),
			st_ff.uscl_ofs, st_ff.uscl_gain);
	end

	// Register the state
	always_ff @(posedge clk)
	begin
		if (reset)
			st_ff <= ST_RST;
		else if (ce)
			st_ff <= nxt;
	end

	assign value = st_ff.value;

endmodule : bcc_vchan

`default_nettype wire

// file: hdl/bcc_top.sv
// Purpose: Calibration scheduling, command mailbox and mode control
// Assumes: process bits, settings and mailbox come from fieldbus logic on clk
// Notes:   Long counts are parameters so a simulation can shorten them
//
// Function
// - Repeat self-calibration every programmed count of 100 ms; default three minutes.
// - Each calibration run occupies the measurement path about 150 ms.
// - Append a 70 ms self-test to every nth run; default n is 10.
// - Inhibit bit suppresses periodic calibration while it is set.
// - Rising edge of manual start bit starts calibration, even when inhibited.
// - Busy flag stands during every calibration and self-test.
// - A started calibration or test always runs to its end.
// - First calibration runs right after start-up; later ones follow the interval timer or a trigger.
// - Any load-settings write forces a calibration, inhibit bit or not.
// - Command 0x0001 zeroes the display with a volatile tare offset.
// - Volatile tare is cleared by reset; the tare control bit triggers it too while the mailbox is idle and takes no request.
// - Command 0x0002 zeroes the display and saves tare to nonvolatile memory.
// - Status reads 255 while executing and 0 after clean completion.
// - Response entry beside status carries an optional result.
// - Commands 0x0101 zero balance and 0x0102 reference calibration are accepted.
// - Voltage mode gives signed 32-bit values saturating at full scale.
// - Load mode by default; alternative layout selects two-channel voltage mode.
// - In voltage mode load settings are dead except averaging for both.
// - No self-calibration in voltage mode.
// - Each voltage channel applies user calibration and user scaling offset and gain.
`default_nettype none

module bcc_top
	import bcc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC,
	parameter int unsigned CAL_CYCLES  = CAL_CYC,
	parameter int unsigned TEST_CYCLES = TEST_CYC
)(
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic               ce,
	input  wire logic               volt_mode,
	input  wire bcc_ctl_type        ctl,
	input  wire bcc_cfg_type        cfg,
	input  wire logic signed [31:0] meas_value,
	input  wire logic signed [31:0] raw_mvv,
	input  wire logic signed [31:0] ch1_raw,
	input  wire logic signed [31:0] ch2_raw,
	input  wire logic               req_wr,
	input  wire logic [15:0]        req_data,
	input  wire logic               nv_ack,
	output logic                    cal_busy,
	output logic                    amp_cal_run,
	output logic                    amp_test_run,
	output logic signed [31:0]      load_value,
	output logic signed [31:0]      ch1_value,
	output logic signed [31:0]      ch2_value,
	output logic                    avg_on,
	output logic [15:0]             command_request,
	output logic [7:0]              command_status,
	output logic [31:0]             command_response,
	output logic                    nv_req,
	output bcc_nv_type              nv_wr
);

	// ----------------
	// State
	// ----------------
	localparam bcc_top_st_type ST_RST = '{
		phase:     PH_IDLE,
		mb:        MB_IDLE,
		boot_pend: 1'b1,
		intv:      DFLT_INTV,
		test_n:    DFLT_TEST_N,
		default:   '0
	};

	bcc_top_st_type st_ff;
	bcc_top_st_type nxt;
	logic           man_edge;
	logic           tare_edge;
	logic           load_cfg;
	logic           new_trig;
	logic           go;
	logic           due;

	// ----------------
	// Periodic timer and voltage channels
	// ----------------
	bcc_sched #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_sched (
		.clk      (clk),
		.reset    (reset),
		.ce       (ce),
		.restart  (go),
		.interval (st_ff.intv),
		.due      (due)
	);

	bcc_vchan #(
		.OBJ (CFG_CH1)
	) u_ch1 (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.cfg   (cfg),
		.raw   (ch1_raw),
		.value (ch1_value)
	);

	bcc_vchan #(
		.OBJ (CFG_CH2)
	) u_ch2 (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.cfg   (cfg),
		.raw   (ch2_raw),
		.value (ch2_value)
	);

	// ----------------
	// Next state
	// ----------------
	always_comb
	begin
		nxt         = st_ff;
		nxt.nv_req  = 1'b0;
		nxt.start_d = ctl.start_cal;
		nxt.tare_d  = ctl.tare;
		man_edge    = ctl.start_cal & ~st_ff.start_d;
		tare_edge   = ctl.tare & ~st_ff.tare_d;
		// Load settings count only in load mode
		load_cfg    = cfg.wr & (cfg.obj == CFG_LOAD) & ~volt_mode;
		// Inhibit gates the timer only
		new_trig    = ~volt_mode & (man_edge | load_cfg | (due & ~ctl.auto_cal_off_flag));
		go          = (st_ff.phase == PH_IDLE) & ~volt_mode
			& (st_ff.boot_pend | st_ff.trig_pend | new_trig);

		// Calibration sequence; no abort path exists
		unique case (st_ff.phase)
			PH_IDLE:
			begin
				if (go)
				begin
					nxt.phase     = PH_CAL;
					nxt.cnt       = CNT_W'(CAL_CYCLES - 1);
					nxt.boot_pend = 1'b0;
					nxt.trig_pend = 1'b0;
				end
			end
			PH_CAL:
			begin
				if (st_ff.cnt != '0)
					nxt.cnt = st_ff.cnt - 1'b1;
				else if (st_ff.test_n != '0 && st_ff.runs + 16'h0001 >= st_ff.test_n)
				begin
					nxt.phase = PH_TEST;
					nxt.cnt   = CNT_W'(TEST_CYCLES - 1);
					nxt.runs  = '0;
				end
				else
				begin
					nxt.phase = PH_IDLE;
					nxt.runs  = st_ff.runs + 16'h0001;
				end
			end
			PH_TEST:
			begin
				if (st_ff.cnt != '0)
					nxt.cnt = st_ff.cnt - 1'b1;
				else
					nxt.phase = PH_IDLE;
			end
			default: nxt.phase = PH_IDLE;
		endcase
		// A trigger during a run is kept for afterwards
		if (new_trig & ~go)
			nxt.trig_pend = 1'b1;

		// Load settings
		if (load_cfg)
		begin
			unique case (cfg.sub)
				SUB_INTV:   nxt.intv   = cfg.data[15:0];
				SUB_TEST_N: nxt.test_n = cfg.data[15:0];
				SUB_TARE:   nxt.tare   = cfg.data;
				default:    ;
			endcase
		end
		// Averager is shared by both modes and both channels
		if (cfg.wr && cfg.obj == CFG_LOAD && cfg.sub == SUB_AVG)
			nxt.avg_on = cfg.data[0];

		// Command mailbox
		unique case (st_ff.mb)
			MB_IDLE:
			begin
				if (req_wr)
				begin
					nxt.req    = req_data;
					nxt.resp   = '0;
					nxt.status = STAT_OK;
					unique case (req_data)
						CMD_NONE: ;
						CMD_TARE_TMP, CMD_TARE_NV, CMD_ZERO, CMD_CAL:
						begin
							nxt.mb     = MB_EXEC;
							nxt.status = STAT_BUSY;
						end
						default:
						begin
							nxt.status = STAT_BAD;
							nxt.resp   = {16'h0000, req_data};
						end
					endcase
				end
				else if (tare_edge)
					nxt.tare = meas_value;
			end
			MB_EXEC:
			begin
				nxt.mb     = MB_IDLE;
				nxt.status = STAT_OK;
				unique case (st_ff.req)
					CMD_TARE_TMP: nxt.tare = meas_value;
					CMD_TARE_NV:
					begin
						nxt.tare    = meas_value;
						nxt.nv.addr = NV_TARE;
						nxt.nv.data = meas_value;
					end
					CMD_ZERO:
					begin
						nxt.zero_bal = raw_mvv;
						nxt.nv.addr  = NV_ZERO;
						nxt.nv.data  = raw_mvv;
					end
					CMD_CAL:
					begin
						nxt.rated   = raw_mvv - st_ff.zero_bal;
						nxt.nv.addr = NV_RATED;
						nxt.nv.data = raw_mvv - st_ff.zero_bal;
					end
					default: ;
				endcase
				// All but the temporary tare go to nonvolatile memory
				if (st_ff.req != CMD_TARE_TMP)
				begin
					nxt.mb     = MB_NV;
					nxt.status = STAT_BUSY;
					nxt.nv_req = 1'b1;
				end
			end
			MB_NV:
			begin
				if (nv_ack)
				begin
					nxt.mb     = MB_IDLE;
					nxt.status = STAT_OK;
				end
			end
			default: nxt.mb = MB_IDLE;
		endcase

		// Display value and run flags
		nxt.load_val = meas_value - st_ff.tare;
		nxt.cal_busy = (nxt.phase != PH_IDLE);
		nxt.amp_cal  = (nxt.phase == PH_CAL);
		nxt.amp_test = (nxt.phase == PH_TEST);
	end

	// Register the state; only power-on reset clears the tare
	always_ff @(posedge clk)
	begin
		if (reset)
			st_ff <= ST_RST;
		else if (ce)
			st_ff <= nxt;
	end

	// ----------------
	// Outputs
	// ----------------
	assign cal_busy         = st_ff.cal_busy;
	assign amp_cal_run      = st_ff.amp_cal;
	assign amp_test_run     = st_ff.amp_test;
	assign load_value       = st_ff.load_val;
	assign avg_on           = st_ff.avg_on;
	assign command_request  = st_ff.req;
	assign command_status   = st_ff.status;
	assign command_response = st_ff.resp;
	assign nv_req           = st_ff.nv_req;
	assign nv_wr            = st_ff.nv;

	// ----------------
	// Assertions
	// ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_busy;
		(st_ff.phase != PH_IDLE) |-> cal_busy && (amp_cal_run ^ amp_test_run);
	endproperty
	a_busy: assert property (p_busy) else $error("busy flag missing");

	property p_no_abort;
		ce && st_ff.phase == PH_CAL && st_ff.cnt != '0 |=> st_ff.phase == PH_CAL;
	endproperty
	a_no_abort: assert property (p_no_abort) else $error("run cut short");

	property p_cal_len;
		$rose(amp_cal_run) |-> st_ff.cnt == CNT_W'(CAL_CYCLES - 1);
	endproperty
	a_cal_len: assert property (p_cal_len) else $error("bad run length");

	property p_test;
		$rose(amp_test_run) |-> st_ff.cnt == CNT_W'(TEST_CYCLES - 1)
			&& $past(st_ff.runs) + 16'h0001 >= st_ff.test_n && $past(amp_cal_run);
	endproperty
	a_test: assert property (p_test) else $error("bad self-test start");

	property p_inhibit;
		ce && st_ff.phase == PH_IDLE && ctl.auto_cal_off_flag && !man_edge && !load_cfg
			&& !st_ff.boot_pend && !st_ff.trig_pend |=> !cal_busy;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("inhibited run");

	property p_manual;
		ce && st_ff.phase == PH_IDLE && !volt_mode && man_edge |=> amp_cal_run;
	endproperty
	a_manual: assert property (p_manual) else $error("manual start lost");

	property p_boot;
		$fell(reset) && ce && !volt_mode |=> amp_cal_run;
	endproperty
	a_boot: assert property (p_boot) else $error("no start-up run");

	property p_cfg_cal;
		ce && st_ff.phase == PH_IDLE && load_cfg |=> amp_cal_run;
	endproperty
	a_cfg_cal: assert property (p_cfg_cal) else $error("settings run lost");

	property p_volt;
		ce && st_ff.phase == PH_IDLE && volt_mode |=> !cal_busy;
	endproperty
	a_volt: assert property (p_volt) else $error("run in voltage mode");

	property p_status;
		st_ff.mb != MB_IDLE |-> command_status == STAT_BUSY;
	endproperty
	a_status: assert property (p_status) else $error("status not busy");

	property p_tare;
		ce && st_ff.mb == MB_EXEC && st_ff.req == CMD_TARE_TMP
			|=> st_ff.tare == $past(meas_value) && command_status == STAT_OK;
	endproperty
	a_tare: assert property (p_tare) else $error("tare not taken");

	property p_nv;
		ce && st_ff.mb == MB_EXEC && st_ff.req == CMD_TARE_NV
			|=> nv_req && nv_wr.addr == NV_TARE && nv_wr.data == $past(meas_value);
	endproperty
	a_nv: assert property (p_nv) else $error("tare not stored");

	c_test:   cover property ($rose(amp_test_run));
	c_nv:     cover property (nv_req ##[1:20] command_status == STAT_OK);
	c_manual: cover property (ctl.auto_cal_off_flag && man_edge ##1 amp_cal_run);
	c_volt:   cover property (volt_mode && ch1_value == V_MAX);

endmodule : bcc_top

`default_nettype wire

// file: bench/bcc_nv_model.sv
// Purpose: Nonvolatile store model on the far side of the store request port
// Assumes: store requests are one-cycle pulses registered on clk
// Notes:   Acknowledges after a programmable number of cycles; counts stores
`default_nettype none

module bcc_nv_model
	import bcc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       nv_req,
	input  wire bcc_nv_type nv_wr,
	input  wire logic [3:0] delay,
	output var  logic       nv_ack
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [31:0] mem [0:3];
	int          stores;

	// Keep each stored word, then answer with one acknowledge pulse after the delay
	initial
	begin
		nv_ack = 1'b0;
		stores = 0;
		forever
		begin
			@(posedge clk);
			#2;
			if (nv_req === 1'b1)
			begin
				mem[nv_wr.addr] = nv_wr.data;
				stores++;
				repeat (delay) @(posedge clk);
				#2 nv_ack = 1'b1;
				@(posedge clk);
				#2 nv_ack = 1'b0;
			end
		end
	end
endmodule : bcc_nv_model
`default_nettype wire

// file: bench/bcc_top_test.sv
// Purpose: Self-checking bench of calibration scheduling, mailbox and voltage mode
// Assumes: shortened tick, run and test counts of 20, 10 and 5 cycles
// Notes:   Inputs change 2 ns after the rising edge; outputs are read there too
`default_nettype none

module bcc_top_test
	import bcc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int TK = 20;
	localparam int CL = 10;
	localparam int TS = 5;

	logic               clk = 1'b0;
	logic               reset = 1'b1;
	logic               volt_mode = 1'b0;
	bcc_ctl_type        ctl = '0;
	bcc_cfg_type        cfg = '0;
	logic signed [31:0] meas_value = '0;
	logic signed [31:0] raw_mvv = '0;
	logic signed [31:0] ch1_raw = '0;
	logic signed [31:0] ch2_raw = '0;
	logic               req_wr = 1'b0;
	logic [15:0]        req_data = '0;
	logic               nv_ack;
	logic [3:0]         nv_dly = 4'h0;
	logic               cal_busy, amp_cal_run, amp_test_run, avg_on, nv_req;
	logic signed [31:0] load_value, ch1_value, ch2_value;
	logic [15:0]        command_request;
	logic [7:0]         command_status;
	logic [31:0]        command_response;
	bcc_nv_type         nv_wr;
	int                 fail_count = 0;
	int                 checks_done = 0;
	int                 cyc = 0;
	int                 st [0:9];
	int                 k, n, t1, t2, hits;

	// Clock and cycle count
	always #10 clk = ~clk;
	always @(posedge clk) cyc++;

	bcc_top #(.TICK_CYCLES(TK), .CAL_CYCLES(CL), .TEST_CYCLES(TS)) i_bcc_top (
		.clk(clk), .reset(reset), .ce(1'b1), .volt_mode(volt_mode), .ctl(ctl), .cfg(cfg),
		.meas_value(meas_value), .raw_mvv(raw_mvv), .ch1_raw(ch1_raw), .ch2_raw(ch2_raw),
		.req_wr(req_wr), .req_data(req_data), .nv_ack(nv_ack), .cal_busy(cal_busy),
		.amp_cal_run(amp_cal_run), .amp_test_run(amp_test_run), .load_value(load_value),
		.ch1_value(ch1_value), .ch2_value(ch2_value), .avg_on(avg_on),
		.command_request(command_request), .command_status(command_status),
		.command_response(command_response), .nv_req(nv_req), .nv_wr(nv_wr));

	bcc_nv_model i_bcc_nv_model (.clk(clk), .nv_req(nv_req), .nv_wr(nv_wr), .delay(nv_dly),
		.nv_ack(nv_ack));

	// ----------------
	// Helpers
	// ----------------
	task automatic finish_test();
		if (fail_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	task automatic step(input int c);
		repeat (c) @(posedge clk);
		#2;
	endtask : step

	task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string msg);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : cmp

	function automatic logic sig(input int s);
		case (s)
			0: return cal_busy === 1'b1;
			1: return amp_cal_run === 1'b1;
			2: return amp_test_run === 1'b1;
			3: return command_status === STAT_OK;
			default: return cal_busy === 1'b0;
		endcase
	endfunction : sig

	// Bounded wait for a condition; running out ends the run
	task automatic wait_hi(input int s, input int lim);
		int i;
		i = 0;
		while (!sig(s) && i < lim)
		begin
			step(1);
			i++;
		end
		if (i >= lim)
		begin
			fail_count++;
			$display("mismatch at %0t: wait %0d ran out", $time, s);
			finish_test();
		end
	endtask : wait_hi

	// Count samples a phase stands, busy must stand with it
	task automatic count_hi(input int s, output int c);
		c = 0;
		while (sig(s) && c < 1000)
		begin
			cmp(cal_busy, 1'b1, "busy during run");
			step(1);
			c++;
		end
	endtask : count_hi

	task automatic cfg_wr(input logic [1:0] obj, input logic [7:0] sub, input logic [31:0] d);
		cfg = '{wr: 1'b1, obj: obj, sub: sub, data: d};
		step(1);
		cfg.wr = 1'b0;
		step(1);
	endtask : cfg_wr

	task automatic req(input logic [15:0] code);
		req_wr = 1'b1;
		req_data = code;
		step(1);
		req_wr = 1'b0;
	endtask : req

	task automatic quiet(input int c);
		hits = 0;
		repeat (c)
		begin
			step(1);
			if (cal_busy !== 1'b0)
				hits++;
		end
	endtask : quiet

	// Storing command: request held off while busy, store word, done after acknowledge
	task automatic nv_cmd(input logic [15:0] code, input logic [1:0] a, input logic [31:0] d,
		input logic [3:0] dly);
		nv_dly = dly;
		req(code);
		cmp(command_status, STAT_BUSY, "store busy");
		step(1);
		cmp(nv_req, 1'b1, "store pulse");
		cmp(nv_wr, {a, d}, "store word");
		req(16'h00AA);
		wait_hi(3, 20);
		cmp(command_request, code, "request kept");
		cmp(command_response, 32'h0000_0000, "store response");
		step(1);
	endtask : nv_cmd

	// ----------------
	// Main sequence
	// ----------------
	initial
	begin
		step(10);
		cmp({command_request, command_status, cal_busy, nv_req}, '0, "reset values");
		reset = 1'b0;
		wait_hi(0, 3);
		count_hi(1, n);
		cmp(n, CL, "boot run");
		wait_hi(0, 1800 * TK + 10);
		cmp(n == CL && cyc > 1800 * TK, 1'b1, "default interval");
		wait_hi(4, 40);
		cfg_wr(CFG_LOAD, SUB_INTV, 32'h2);
		cfg_wr(CFG_LOAD, SUB_TEST_N, 32'h3);
		wait_hi(4, 40);
		t1 = -1;
		t2 = -1;
		for (k = 0; k < 10; k++)
		begin
			wait_hi(0, 200);
			st[k] = cyc;
			count_hi(1, n);
			cmp(n, CL, "run length");
			if (amp_test_run === 1'b1)
			begin
				count_hi(2, n);
				cmp(n, TS, "test length");
				if (t1 < 0)
					t1 = k;
				else if (t2 < 0)
					t2 = k;
			end
			if (k >= 5)
				cmp((st[k] - st[k-1]) inside {[2*TK:2*TK+2]}, 1'b1, "period");
		end
		cmp(t2 - t1, 3, "test spacing");
		wait_hi(4, 40);
		ctl.auto_cal_off_flag = 1'b1;
		step(2);
		wait_hi(4, 40);
		quiet(150);
		cmp(hits, 0, "inhibited");
		ctl.start_cal = 1'b1;
		wait_hi(0, 3);
		ctl = '{start_cal: 1'b0, auto_cal_off_flag: 1'b0, tare: 1'b0};
		step(1);
		ctl.auto_cal_off_flag = 1'b1;
		count_hi(1, n);
		cmp(n, CL - 1, "manual run not cut");
		wait_hi(4, 40);
		cfg_wr(CFG_LOAD, SUB_AVG, 32'h0);
		wait_hi(0, 3);
		wait_hi(4, 40);
		volt_mode = 1'b1;
		ctl = '{start_cal: 1'b1, auto_cal_off_flag: 1'b0, tare: 1'b0};
		meas_value = 100;
		cfg_wr(CFG_LOAD, SUB_AVG, 32'h1);
		cfg_wr(CFG_LOAD, SUB_TARE, 32'd777);
		cmp(avg_on, 1'b1, "averager in voltage mode");
		cfg_wr(CFG_CH1, SUB_UCAL_OFS, 32'h100);
		cfg_wr(CFG_CH1, SUB_UCAL_GAIN, 32'h2_0000);
		cfg_wr(CFG_CH2, SUB_USCL_OFS, -32'sd16);
		cfg_wr(CFG_CH2, SUB_USCL_GAIN, 32'h8000);
		ch1_raw = 32'sh1000;
		ch2_raw = 32'sh40;
		quiet(100);
		cmp(hits, 0, "no run in voltage mode");
		cmp(load_value, 34'd100, "tare write dead");
		cmp(ch1_value, 34'h2200, "ch1 user cal");
		cmp(ch2_value, 34'h18, "ch2 user scale");
		ch1_raw = 32'sh7000_0000;
		step(3);
		cmp(ch1_value, V_MAX, "positive full scale");
		ch1_raw = 32'sh9000_0000;
		step(3);
		cmp(ch1_value, V_MIN, "negative full scale");
		volt_mode = 1'b0;
		ctl = '{start_cal: 1'b0, auto_cal_off_flag: 1'b1, tare: 1'b0};
		meas_value = 1000;
		req(CMD_TARE_TMP);
		cmp(command_status, STAT_BUSY, "tare busy");
		step(1);
		cmp(command_status, STAT_OK, "tare done");
		meas_value = 1500;
		step(2);
		cmp(load_value, 34'd500, "volatile tare");
		ctl.tare = 1'b1;
		step(3);
		cmp(load_value, 34'd0, "tare bit");
		ctl.tare = 1'b0;
		nv_cmd(CMD_TARE_NV, NV_TARE, 32'd1500, 4'h6);
		raw_mvv = 300;
		nv_cmd(CMD_ZERO, NV_ZERO, 32'd300, 4'h0);
		raw_mvv = 800;
		nv_cmd(CMD_CAL, NV_RATED, 32'd500, 4'h3);
		req(16'h0055);
		cmp({command_status, command_response}, {STAT_BAD, 32'h55}, "unknown");
		step(1);
		req(CMD_NONE);
		cmp({command_request, command_status, command_response}, '0, "mailbox reset");
		cmp(i_bcc_nv_model.stores, 3, "store count");
		cmp(i_bcc_nv_model.mem[NV_RATED], 32'd500, "stored rated word");
		finish_test();
	end

	// Whole-run limit
	initial
	begin
		repeat (80000) @(posedge clk);
		fail_count++;
		$display("mismatch at %0t: run limit", $time);
		finish_test();
	end
endmodule : bcc_top_test
`default_nettype wire
